/* logic/vam_defs.svh */
`ifndef VAM_DEFS_SVH
`define VAM_DEFS_SVH

// register offsets (byte addresses)
`define VAM_OFS_CTRL 8'h00
`define VAM_OFS_VTHR 8'h04
`define VAM_OFS_ITHR 8'h08
`define VAM_OFS_MAXT 8'h0C
`define VAM_OFS_STAT 8'h10
`define VAM_OFS_EVT 8'h14
`define VAM_OFS_MASK 8'h18
`define VAM_OFS_HELD 8'h1C
`define VAM_OFS_THDA 8'h20
`define VAM_OFS_THDP 8'h24
`define VAM_OFS_FREQ 8'h28
`define VAM_OFS_ANG 8'h40
`define VAM_OFS_HARM 8'h80

// control field positions
`define VAM_CTRL_EN 0
`define VAM_CTRL_CUREN 1
`define VAM_CTRL_FORCECT 2
`define VAM_CTRL_FIX60 3
`define VAM_CTRL_HABS 4
`define VAM_CTRL_HDISP_LO 5
`define VAM_CTRL_MODE_LO 7
`define VAM_CTRL_USED_LO 9
`define VAM_CTRL_SYNC3 15
`define VAM_CTRL_SYNC4 16
`define VAM_MODE_SYNC 2'h2

// reset values
`define VAM_RST_CTRL 32'h00007E00
`define VAM_RST_VTHR 16'h07D0
`define VAM_RST_ITHR 16'h0064
`define VAM_RST_MAXT 16'h0032

// limits: voltage in 10 mV, time in 10 ms, angle in 0.01 deg, freq in 0.01 Hz
`define VAM_VTHR_MIN 16'h00C8
`define VAM_VTHR_MAX 16'h1388
`define VAM_MAXT_MIN 16'h0002
`define VAM_MAXT_MAX 16'h1388
`define VAM_ANG_LIMIT 16'h8CA0
`define VAM_FREQ_50 16'h1388
`define VAM_FREQ_60 16'h1770
`define VAM_ANG_COUNT 9

// timing: one time step of the active-time limit
`define VAM_STEP_NS 10000000
`define VAM_CLK_PERIOD_NS 5
`define VAM_STEP_CYCLES (`VAM_STEP_NS / `VAM_CLK_PERIOD_NS)

`endif

/* logic/vam_pkg.sv */
package vam_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_EXPIRED = 2'b10
    } vam_state_t;

    typedef struct packed {
        vam_state_t st;
        logic [31:0] ctrl;
        logic [15:0] vThr;
        logic [15:0] iThr;
        logic [15:0] maxTime;
        logic [11:0] evtStat;
        logic [11:0] evtMask;
        logic [1:0] blkSync;
        logic blocked;
        logic voltLow;
        logic curHigh;
        logic freqFromCt;
        logic [15:0] preAngle;
        logic [15:0] heldAngle;
        logic [21:0] stepCnt;
        logic [15:0] elapsed;
        logic inUse;
        logic nonDir;
        logic [15:0] angleOut;
        logic [15:0] ampOut;
        logic [15:0] sampFreq;
        logic [31:0] rdata;
        logic irq;
        logic [15:0] thdAmp;
        logic [15:0] thdPow;
        logic [8:0][15:0] ang;
        logic [31:0][31:0] harm;
    } vam_regs_t;

    typedef struct packed {
        logic [5:0] prev;
        logic [11:0] pulse;
    } vam_edge_t;

endpackage : vam_pkg

/* logic/vam_event_edge.sv */
`timescale 1ns/1ps

module vam_event_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] lvl,
    output logic [11:0] evtPulse
);
    import vam_pkg::*;

    vam_edge_t s_reg;
    vam_edge_t s_next;

    // on event in even bit, off event in odd bit of each pair
    always_comb begin
        s_next = s_reg;
        s_next.prev = lvl;
        for (int i = 0; i < 6; i++) begin
            s_next.pulse[2 * i] = lvl[i] & ~s_reg.prev[i];
            s_next.pulse[2 * i + 1] = ~lvl[i] & s_reg.prev[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign evtPulse = s_reg.pulse;

endmodule : vam_event_edge

/* logic/vam_voltage_memory.sv */
`timescale 1ns/1ps
`include "vam_defs.svh"

module vam_voltage_memory #(
    parameter int STEP_CYCLES = `VAM_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic cycleStart,
    input wire logic blockIn,
    input wire logic [5:0][15:0] voltMag,
    input wire logic [2:0][15:0] curMag,
    input wire logic [15:0] voltAngle,
    input wire logic [15:0] phase3CurrentFreq,
    input wire logic harmValid,
    input wire logic [4:0] harmIndex,
    input wire logic [31:0] harmValue,
    input wire logic thdValid,
    input wire logic [15:0] thdAmpIn,
    input wire logic [15:0] thdPowIn,
    input wire logic angValid,
    input wire logic [3:0] angIndex,
    input wire logic [15:0] angValue,
    output logic memInUse,
    output logic nonDirectional,
    output logic [15:0] memAngle,
    output logic [15:0] memAmplitude,
    output logic [15:0] samplingFreq,
    output logic harmAbsolute,
    output logic [1:0] harmDisplay,
    output logic [11:0] evtPulse
);
    import vam_pkg::*;

    vam_regs_t r_reg;
    vam_regs_t r_next;
    logic [11:0] edgePulse;
    logic [5:0] evtLevels;

    // clamp a value into an inclusive range
    function automatic logic [15:0] clampRange(input logic [15:0] v, input logic [15:0] lo,
                                               input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clampRange

    // true while the synchrocheck angle channels hold meaningful data
    function automatic logic syncValid(input logic [31:0] c);
        return (c[`VAM_CTRL_MODE_LO +: 2] == `VAM_MODE_SYNC) && c[`VAM_CTRL_SYNC3] && c[`VAM_CTRL_SYNC4];
    endfunction : syncValid

    // read mux shared by the read path
    function automatic logic [31:0] regRead(input logic [7:0] a, input vam_regs_t r);
        logic [3:0] ai;
        ai = a[5:2];
        regRead = 32'h00000000;
        if (a[7]) begin
            regRead = r.harm[a[6:2]];
        end else if (a[7:6] == 2'h1) begin
            // sync channels 7 and 8 read zero unless valid
            if (ai < 4'h7 || (ai < 4'h9 && syncValid(r.ctrl))) begin
                regRead = {16'h0000, r.ang[ai]};
            end
        end else begin
            unique case (a)
                `VAM_OFS_CTRL: regRead = r.ctrl;
                `VAM_OFS_VTHR: regRead = {16'h0000, r.vThr};
                `VAM_OFS_ITHR: regRead = {16'h0000, r.iThr};
                `VAM_OFS_MAXT: regRead = {16'h0000, r.maxTime};
                `VAM_OFS_STAT: regRead = {24'h000000, syncValid(r.ctrl), r.nonDir, r.blocked,
                                          r.freqFromCt, r.curHigh, r.voltLow, r.st};
                `VAM_OFS_EVT: regRead = {20'h00000, r.evtStat};
                `VAM_OFS_MASK: regRead = {20'h00000, r.evtMask};
                `VAM_OFS_HELD: regRead = {16'h0000, r.heldAngle};
                `VAM_OFS_THDA: regRead = {16'h0000, r.thdAmp};
                `VAM_OFS_THDP: regRead = {16'h0000, r.thdPow};
                `VAM_OFS_FREQ: regRead = {16'h0000, r.sampFreq};
                default: regRead = 32'h00000000;
            endcase
        end
    endfunction : regRead

    // level conditions whose edges become log events
    assign evtLevels = {r_reg.blocked, r_reg.inUse, r_reg.freqFromCt, r_reg.curHigh, r_reg.voltLow,
                        r_reg.ctrl[`VAM_CTRL_EN]};

    vam_event_edge u_edge (
        .clk(clk),
        .rst(rst),
        .lvl(evtLevels),
        .evtPulse(edgePulse)
    );

    // next-state logic for the whole block
    always_comb begin
        logic low;
        logic anyUsed;
        logic high;
        logic cond;
        logic blkNow;
        logic stepDone;
        logic [11:0] clr;
        logic [15:0] nextElapsed;
        low = 1'b1;
        anyUsed = 1'b0;
        high = 1'b0;
        cond = 1'b0;
        blkNow = 1'b0;
        stepDone = 1'b0;
        clr = 12'h000;
        nextElapsed = 16'h0000;
        r_next = r_reg;

        // register writes; limits are forced so software cannot leave the range
        if (wrStb) begin
            unique case (addr)
                `VAM_OFS_CTRL: r_next.ctrl = wdata;
                `VAM_OFS_VTHR: r_next.vThr = clampRange(wdata[15:0], `VAM_VTHR_MIN, `VAM_VTHR_MAX);
                `VAM_OFS_ITHR: r_next.iThr = wdata[15:0];
                `VAM_OFS_MAXT: r_next.maxTime = clampRange(wdata[15:0], `VAM_MAXT_MIN, `VAM_MAXT_MAX);
                `VAM_OFS_EVT: clr = wdata[11:0];
                `VAM_OFS_MASK: r_next.evtMask = wdata[11:0];
                default: clr = 12'h000;
            endcase
        end

        // read data stands in the cycle after the strobe only
        r_next.rdata = rdStb ? regRead(addr, r_reg) : 32'h00000000;

        // block pin is asynchronous: two flops before use
        r_next.blkSync = {r_reg.blkSync[0], blockIn};
        if (cycleStart) begin
            r_next.blocked = r_reg.blkSync[1];
        end
        blkNow = cycleStart ? r_reg.blkSync[1] : r_reg.blocked;

        for (int i = 0; i < 6; i++) begin
            if (r_reg.ctrl[`VAM_CTRL_USED_LO + i]) begin
                anyUsed = 1'b1;
                if (voltMag[i] >= r_reg.vThr) begin
                    low = 1'b0;
                end
            end
        end
        low = low & anyUsed;
        for (int i = 0; i < 3; i++) begin
            if (curMag[i] > r_reg.iThr) begin
                high = 1'b1;
            end
        end
        r_next.voltLow = low;
        r_next.curHigh = high;
        cond = r_reg.ctrl[`VAM_CTRL_EN] && low && (!r_reg.ctrl[`VAM_CTRL_CUREN] || high);

        // active-time base: one step of 10 ms
        stepDone = (r_reg.stepCnt == 22'(STEP_CYCLES - 1));
        nextElapsed = r_reg.elapsed + 16'h0001;

        unique case (r_reg.st)
            ST_IDLE: begin
                if (cycleStart && !low) begin
                    r_next.preAngle = voltAngle;
                end
                if (cycleStart && cond && !blkNow) begin
                    r_next.st = ST_ACTIVE;
                    r_next.heldAngle = r_reg.preAngle;
                    r_next.stepCnt = 22'h000000;
                    r_next.elapsed = 16'h0000;
                end
            end
            ST_ACTIVE: begin
                r_next.stepCnt = stepDone ? 22'h000000 : r_reg.stepCnt + 22'h000001;
                if (stepDone) begin
                    r_next.elapsed = nextElapsed;
                end
                if (cycleStart && (!cond || blkNow)) begin
                    r_next.st = ST_IDLE;
                end else if (stepDone && nextElapsed >= r_reg.maxTime) begin
                    r_next.st = ST_EXPIRED;
                end
            end
            ST_EXPIRED: begin
                if (cycleStart && (!cond || blkNow)) begin
                    r_next.st = ST_IDLE;
                end
            end
            default: r_next.st = ST_IDLE;
        endcase

        r_next.inUse = (r_next.st == ST_ACTIVE);
        // expired means directional stages trip non-directionally
        r_next.nonDir = (r_next.st == ST_EXPIRED);
        r_next.angleOut = r_next.inUse ? r_next.heldAngle : voltAngle;
        r_next.ampOut = r_next.inUse ? r_reg.vThr : voltMag[0];

        r_next.freqFromCt = r_reg.ctrl[`VAM_CTRL_FORCECT] && low;
        if (r_next.freqFromCt) begin
            r_next.sampFreq = phase3CurrentFreq;
        end else begin
            r_next.sampFreq = r_reg.ctrl[`VAM_CTRL_FIX60] ? `VAM_FREQ_60 : `VAM_FREQ_50;
        end

        if (harmValid) begin
            r_next.harm[harmIndex] = harmValue;
        end
        if (thdValid) begin
            r_next.thdAmp = thdAmpIn;
            r_next.thdPow = thdPowIn;
        end
        if (angValid && angIndex < 4'(`VAM_ANG_COUNT) && angValue < `VAM_ANG_LIMIT) begin
            r_next.ang[angIndex] = angValue;
        end

        // sticky events: a new event wins over a same-cycle clear
        r_next.evtStat = (r_reg.evtStat & ~clr) | edgePulse;
        r_next.irq = |(r_next.evtStat & r_next.evtMask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ctrl <= `VAM_RST_CTRL;
            r_reg.vThr <= `VAM_RST_VTHR;
            r_reg.iThr <= `VAM_RST_ITHR;
            r_reg.maxTime <= `VAM_RST_MAXT;
            r_reg.sampFreq <= `VAM_FREQ_50;
        end else begin
            r_reg <= r_next;
        end
    end

    // every output comes from a register
    assign rdata = r_reg.rdata;
    assign irq = r_reg.irq;
    assign memInUse = r_reg.inUse;
    assign nonDirectional = r_reg.nonDir;
    assign memAngle = r_reg.angleOut;
    assign memAmplitude = r_reg.ampOut;
    assign samplingFreq = r_reg.sampFreq;
    assign harmAbsolute = r_reg.ctrl[`VAM_CTRL_HABS];
    assign harmDisplay = r_reg.ctrl[`VAM_CTRL_HDISP_LO +: 2];
    assign evtPulse = edgePulse;

endmodule : vam_voltage_memory

/* test/vam_meas_model.sv */
`timescale 1ns/1ps
// voltage and current channels in front of the memory block
module vam_meas_model (
    input wire logic clk,
    input wire logic fault,
    input wire logic curHi,
    input wire logic [15:0] angSet,
    output logic [5:0][15:0] voltMag,
    output logic [2:0][15:0] curMag,
    output logic [15:0] voltAngle,
    output logic [15:0] phase3CurrentFreq
);
    logic [15:0] noiseReg = 16'h0000;
    // a collapsed voltage has no usable angle, so it wanders every cycle
    always_ff @(posedge clk) begin
        noiseReg <= noiseReg + 16'h0101;
    end
    // 100 V healthy, 0.99 V in a close-in fault
    assign voltMag = {6{fault ? 16'h2710 ^ 16'h2773 : 16'h2710}};
    assign curMag = {3{curHi ? 16'h0200 : 16'h0010}};
    assign voltAngle = fault ? noiseReg : angSet;
    assign phase3CurrentFreq = 16'h11F8; // 46 Hz on the phase 3 current
endmodule : vam_meas_model

/* test/vam_voltage_memory_monitor.sv */
`timescale 1ns/1ps
module vam_voltage_memory_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic rdStb,
    input wire logic [31:0] rdata,
    input wire logic cycleStart,
    input wire logic memInUse,
    input wire logic nonDirectional,
    input wire logic [15:0] memAngle,
    input wire logic [15:0] memAmplitude,
    input wire logic [11:0] evtPulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    start_on_cycle_a: assert property ($rose(memInUse) |-> $past(cycleStart))
        else $error("memory started off a cycle start");
    stop_cause_a: assert property (!$past(rst) && $fell(memInUse) && !$past(cycleStart) |-> ##[0:1] nonDirectional)
        else $error("memory dropped without cycle start or expiry");
    amp_hold_a: assert property (memInUse && $past(memInUse) |-> $stable(memAmplitude))
        else $error("amplitude moved while memory in use");
    angle_hold_a: assert property (memInUse && $past(memInUse) |-> $stable(memAngle))
        else $error("angle moved while memory in use");
    expiry_order_a: assert property ($rose(nonDirectional) |-> $past(memInUse) || $past(memInUse, 2))
        else $error("non-directional without prior memory use");
    state_excl_a: assert property (!(memInUse && nonDirectional))
        else $error("memory in use while non-directional");
    use_on_evt_a: assert property ($rose(memInUse) |=> evtPulse[8] ##1 !evtPulse[8])
        else $error("missing in-use on event");
    use_off_evt_a: assert property (!$past(rst) && $fell(memInUse) |=> evtPulse[9])
        else $error("missing in-use off event");
    // read data idles at zero
    rdata_idle_a: assert property (!$past(rdStb) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    cover property ($rose(memInUse));
    cover property ($rose(nonDirectional));
    cover property (memInUse && cycleStart);
endmodule : vam_voltage_memory_monitor

bind vam_voltage_memory vam_voltage_memory_monitor mon (.clk, .rst, .rdStb, .rdata, .cycleStart, .memInUse,
    .nonDirectional, .memAngle, .memAmplitude, .evtPulse);

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam int STEP = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, harmValue = 32'h0, v, rdata;
    logic wrStb = 1'b0, rdStb = 1'b0, cycleStart = 1'b0, blockIn = 1'b0, fault = 1'b0, curHi = 1'b0;
    logic harmValid = 1'b0, thdValid = 1'b0, angValid = 1'b0;
    logic [4:0] harmIndex = 5'h00;
    logic [3:0] angIndex = 4'h0;
    logic [15:0] angSet = 16'h1234, thdAmpIn = 16'h0, thdPowIn = 16'h0, angValue = 16'h0;
    logic irq, memInUse, nonDirectional, harmAbsolute;
    logic [1:0] harmDisplay;
    logic [11:0] evtPulse;
    logic [15:0] memAngle, memAmplitude, samplingFreq, voltAngle, phase3CurrentFreq;
    logic [5:0][15:0] voltMag;
    logic [2:0][15:0] curMag;
    int nMismatch = 0, cmpCount = 0, k;
    // {write, address, data, expected read}
    logic [72:0] rows [14] = '{{1'b0, 8'h00, 32'h0, 32'h7E00}, {1'b0, 8'h04, 32'h0, 32'h07D0},
        {1'b0, 8'h08, 32'h0, 32'h0064}, {1'b0, 8'h0C, 32'h0, 32'h0032}, {1'b0, 8'h10, 32'h0, 32'h0},
        {1'b0, 8'h14, 32'h0, 32'h0}, {1'b0, 8'h18, 32'h0, 32'h0}, {1'b0, 8'h28, 32'h0, 32'h1388},
        {1'b1, 8'h3C, 32'hFFFFFFFF, 32'h0}, {1'b1, 8'h04, 32'h1, 32'h00C8}, {1'b1, 8'h04, 32'hFFFF, 32'h1388},
        {1'b1, 8'h0C, 32'h0, 32'h2}, {1'b1, 8'h0C, 32'hFFFF, 32'h1388}, {1'b1, 8'h10, 32'hFF, 32'h0}};

    always #2.5 clk = ~clk;

    vam_voltage_memory #(.STEP_CYCLES(STEP)) dut (.clk, .rst, .addr, .wdata, .wrStb, .rdStb, .rdata, .irq,
        .cycleStart, .blockIn, .voltMag, .curMag, .voltAngle, .phase3CurrentFreq, .harmValid, .harmIndex,
        .harmValue, .thdValid, .thdAmpIn, .thdPowIn, .angValid, .angIndex, .angValue, .memInUse,
        .nonDirectional, .memAngle, .memAmplitude, .samplingFreq, .harmAbsolute, .harmDisplay, .evtPulse);
    vam_meas_model chan (.clk, .fault, .curHi, .angSet, .voltMag, .curMag, .voltAngle, .phase3CurrentFreq);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // strobes drop at the edge and rise 1 ns later, never twice in one step
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 v = rdata;
    endtask : rd
    // one program cycle start, then the cycle in which the state shows
    task automatic pulse;
        cycleStart <= 1'b1;
        tick(1);
        cycleStart <= 1'b0;
        tick(1);
    endtask : pulse
    task automatic testDone;
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : testDone

    // a whole run takes about 200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        testDone();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(samplingFreq, 16'h1388);
        for (k = 0; k < 14; k++) begin
            if (rows[k][72]) wr(rows[k][71:64], rows[k][63:32]);
            rd(rows[k][71:64]);
            chk(v, rows[k][31:0]);
        end
        // enable event stays off the line while masked
        wr(8'h04, 32'h07D0);
        wr(8'h0C, 32'h3);
        wr(8'h00, 32'h7E01);
        tick(2);
        chk(irq, 1'b0);
        rd(8'h14);
        chk(v[0], 1'b1);
        wr(8'h18, 32'hFFF);
        tick(2);
        chk(irq, 1'b1);
        wr(8'h14, 32'hFFF);
        tick(2);
        chk(irq, 1'b0);
        // healthy cycle latches the angle, then the voltages collapse
        pulse();
        fault <= 1'b1;
        tick(3);
        pulse();
        chk(memInUse, 1'b1);
        chk(memAmplitude, 16'h07D0);
        chk(memAngle, 16'h1234);
        k = 0;
        while (memInUse === 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        // the count starts one cycle into the active span
        chk(k, 3 * STEP - 1);
        tick(1);
        chk(nonDirectional, 1'b1);
        pulse();
        chk(memInUse, 1'b0);
        angSet <= 16'h2345;
        fault <= 1'b0;
        tick(3);
        pulse();
        chk(nonDirectional, 1'b0);
        // a healthy cycle start in idle takes the new pre-fault angle
        pulse();
        // blocking input through its synchroniser
        blockIn <= 1'b1;
        fault <= 1'b1;
        tick(4);
        pulse();
        chk(memInUse, 1'b0);
        blockIn <= 1'b0;
        tick(4);
        pulse();
        chk(memAngle, 16'h2345);
        blockIn <= 1'b1;
        tick(4);
        pulse();
        chk(memInUse, 1'b0);
        rd(8'h14);
        chk(v[11:8], 4'hF);
        // optional current condition
        blockIn <= 1'b0;
        fault <= 1'b0;
        wr(8'h00, 32'h7E03);
        tick(4);
        pulse();
        fault <= 1'b1;
        tick(3);
        pulse();
        chk(memInUse, 1'b0);
        curHi <= 1'b1;
        tick(3);
        pulse();
        chk(memInUse, 1'b1);
        fault <= 1'b0;
        tick(3);
        pulse();
        chk(memInUse, 1'b0);
        // sampling frequency sources
        wr(8'h00, 32'h7E05);
        fault <= 1'b1;
        tick(3);
        chk(samplingFreq, 16'h11F8);
        fault <= 1'b0;
        tick(3);
        chk(samplingFreq, 16'h1388);
        wr(8'h00, 32'h7E0D);
        tick(3);
        chk(samplingFreq, 16'h1770);
        for (k = 0; k < 6; k++) begin
            wr(8'h00, 32'h7E00 | (k << 4));
            tick(1);
            chk({harmDisplay, harmAbsolute}, k);
        end
        for (k = 0; k < 32; k++) begin
            harmIndex <= k[4:0];
            harmValue <= 32'hA5000000 | k;
            harmValid <= 1'b1;
            tick(1);
            harmValid <= 1'b0;
            rd(8'h80 + 8'(k * 4));
            chk(v, 32'hA5000000 | k);
        end
        thdAmpIn <= 16'h0123;
        thdPowIn <= 16'h0456;
        thdValid <= 1'b1;
        tick(1);
        thdValid <= 1'b0;
        rd(8'h20);
        chk(v, 32'h0123);
        rd(8'h24);
        chk(v, 32'h0456);
        // 359.99 kept, 360.00 dropped, sync angle hidden outside sync mode
        angValue <= 16'h8C9F;
        angValid <= 1'b1;
        tick(1);
        angValue <= 16'h8CA0;
        tick(1);
        angIndex <= 4'h7;
        angValue <= 16'h0BB8;
        tick(1);
        angValid <= 1'b0;
        rd(8'h40);
        chk(v, 32'h8C9F);
        rd(8'h5C);
        chk(v, 32'h0);
        wr(8'h00, 32'h0001FF00);
        rd(8'h5C);
        chk(v, 32'h0BB8);
        testDone();
    end
endmodule : tb
